// ### hdl/pmcc_defs.svh
// constants for the conversion control register bank
`ifndef PMCC_DEFS_SVH
`define PMCC_DEFS_SVH

// ----------------------------------------------------------------
// command codes
// ----------------------------------------------------------------
`define PMCC_CMD_OP 8'h01
`define PMCC_CMD_CFG 8'h02
`define PMCC_CMD_CLR 8'h03
`define PMCC_CMD_PHASE 8'h04
`define PMCC_CMD_CML 8'h7E
`define PMCC_CMD_FLT 8'h7F
`define PMCC_ARA_ADDR 7'h0C

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define PMCC_OP_RST 8'h04
`define PMCC_CFG_RST 8'h16
`define PMCC_MRG_RST 4'h1

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define PMCC_OP_ON 7
`define PMCC_OP_SOFT 6
`define PMCC_CFG_START 4
`define PMCC_CFG_CMD 3
`define PMCC_CFG_PINEN 2
`define PMCC_CFG_PINHI 1
`define PMCC_CFG_PINOFF 0
`define PMCC_CML_BADC 7
`define PMCC_CML_IVD 6

// ----------------------------------------------------------------
// margin codes
// ----------------------------------------------------------------
`define PMCC_MRG_OFF0 4'h0
`define PMCC_MRG_OFF1 4'h1
`define PMCC_MRG_OFF2 4'h2
`define PMCC_MRG_LO_IGN 4'h5
`define PMCC_MRG_LO_ACT 4'h6
`define PMCC_MRG_HI_IGN 4'h9
`define PMCC_MRG_HI_ACT 4'hA

// ----------------------------------------------------------------
// access kinds
// ----------------------------------------------------------------
`define PMCC_K_CMD 2'h0
`define PMCC_K_WR 2'h1
`define PMCC_K_RD 2'h2

`endif

// ### hdl/pmcc_pkg.sv
// types for the conversion control register bank
package pmcc_pkg;
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0000,
		ST_ADDR = 4'b0001,
		ST_ADDR_ACK = 4'b0010,
		ST_CMD = 4'b0011,
		ST_CMD_ACK = 4'b0100,
		ST_WDATA = 4'b0101,
		ST_WACK = 4'b0110,
		ST_RDATA = 4'b0111,
		ST_RACK = 4'b1000,
		ST_IGNORE = 4'b1001
	} pmcc_state_e;
	typedef enum logic [1:0] {
		MSEL_NOM = 2'b00,
		MSEL_LOW = 2'b01,
		MSEL_HIGH = 2'b10
	} pmcc_margin_e;
endpackage : pmcc_pkg

// ### hdl/pmcc_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module pmcc_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] INIT = '0
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_r;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			meta_r <= INIT;
			q <= INIT;
		end else begin
			meta_r <= d;
			q <= meta_r;
		end
	end
endmodule : pmcc_sync

// ### hdl/pmcc_run_ctrl.sv
// start and stop decision for power conversion
`timescale 1ns/1ps
module pmcc_run_ctrl (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic vin_ok,
	input wire logic pin,
	input wire logic secondary,
	input wire logic op_on,
	input wire logic op_soft,
	input wire logic cfg_start,
	input wire logic cfg_cmd,
	input wire logic cfg_pinen,
	input wire logic cfg_pinoff,
	output logic run_r,
	output logic soft_r,
	output logic run_on
);
	logic start_eff;
	logic cmd_ok;
	logic pin_ok;
	logic want;

	assign start_eff = cfg_start & ~secondary;
	assign cmd_ok = ~cfg_cmd | op_on;
	assign pin_ok = ~cfg_pinen | pin;
	assign want = vin_ok & (~start_eff | (cmd_ok & pin_ok & (cfg_cmd | cfg_pinen)));
	assign run_on = want & ~run_r;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			run_r <= 1'b0;
		end else begin
			run_r <= want;
		end
	end

	// off profile from the pin off bit when the pin path is enabled and the pin is low, else from the off bit
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			soft_r <= 1'b0;
		end else if (run_r && !want) begin
			if (cfg_pinen && !pin) begin
				soft_r <= ~cfg_pinoff;
			end else begin
				soft_r <= op_soft;
			end
		end
	end

	start_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
		(vin_ok && !start_eff) |=> run_r) else $error("start without enable path failed");
	pin_off_soft_a: assert property (@(posedge clk) disable iff (!rst_n)
		(run_r && start_eff && cfg_pinen && !pin) |=> (!run_r && soft_r == !$past(cfg_pinoff)))
		else $error("pin off profile wrong");
endmodule : pmcc_run_ctrl

// ### hdl/pmcc_top.sv
// command register bank behind the smbus target port
`timescale 1ns/1ps
`include "pmcc_defs.svh"
// Notes on behaviour
// - multi-byte values go low byte first
// - on bit enables conversion when permitted
// - secondary reads and acts with on=1
// - off bit picks immediate or soft stop
// - margin resets to 0001, codes 0-2 nominal
// - 0101 low ignore faults, 0110 low act
// - 1001 high ignore faults, 1010 high act
// - reserved bits always read zero
// - unlisted write values flag invalid data, alert
// - start bit 0 runs whenever input present
// - command bit selects conversion command path
// - pin path bit selects control pin path
// - polarity bit fixed at one
// - pin off action: soft or immediate stop
// - secondary acts start bit 0, drops config writes
// - secondary config access nacked, flags, alerts
// - clear faults clears status, releases alert
// - clear never restarts; persisting fault resets
// - alert response drops alert, keeps status
// - pending sources masked until cleared
// - new sources after response alert again
// - phase register returns stack position
module pmcc_top import pmcc_pkg::*; #(
	parameter int NF = 4,
	parameter logic [7:0] CFG_RST = `PMCC_CFG_RST
) (
	input wire logic MCLK,
	input wire logic RST_N,
	input wire logic SCL_I,
	input wire logic SDA_I,
	output logic SDA_O,
	output logic SDA_OE,
	output logic ALERT_O,
	output logic ALERT_OE,
	input wire logic [6:0] DEV_ADDR,
	input wire logic SECONDARY,
	input wire logic [1:0] STACK_POS,
	input wire logic CONTROL_PIN,
	input wire logic VIN_OK,
	input wire logic [NF-1:0] FAULT_IN,
	output logic CONV_RUN,
	output logic OFF_SOFT,
	output logic [1:0] MARGIN_SEL,
	output logic FAULT_IGNORE
);
	localparam int NS = NF + 2;
	localparam int SW = NF + 14;
	localparam int IVD = NF;
	localparam int BADC = NF + 1;

	// ----------------------------------------------------------------
	// decode functions
	// ----------------------------------------------------------------
	function automatic logic acc_f(input logic [7:0] c, input logic [1:0] k, input logic sec);
		case (c)
			`PMCC_CMD_OP, `PMCC_CMD_CML, `PMCC_CMD_FLT: acc_f = 1'b1;
			`PMCC_CMD_CFG: acc_f = ~sec;
			`PMCC_CMD_CLR: acc_f = (k == `PMCC_K_CMD);
			`PMCC_CMD_PHASE: acc_f = (k != `PMCC_K_WR);
			default: acc_f = 1'b0;
		endcase
	endfunction : acc_f

	function automatic logic op_valid_f(input logic [7:0] v);
		case (v[5:2])
			`PMCC_MRG_OFF0, `PMCC_MRG_OFF1, `PMCC_MRG_OFF2, `PMCC_MRG_LO_IGN,
			`PMCC_MRG_LO_ACT, `PMCC_MRG_HI_IGN, `PMCC_MRG_HI_ACT: op_valid_f = (v[1:0] == 2'b00);
			default: op_valid_f = 1'b0;
		endcase
	endfunction : op_valid_f

	function automatic logic cfg_valid_f(input logic [7:0] v);
		cfg_valid_f = (v[7:5] == 3'b000) && v[`PMCC_CFG_PINHI];
	endfunction : cfg_valid_f

	// ----------------------------------------------------------------
	// pin synchronisers and bus edges
	// ----------------------------------------------------------------
	logic [SW-1:0] pins_s;
	logic scl_s, sda_s, scl_p, sda_p, sec_s, pin_s, vin_s;
	logic [6:0] dev_s;
	logic [1:0] stack_s;
	logic [NF-1:0] flt_s;
	logic scl_rise, scl_fall, start_ev, stop_ev;

	// bus lines start at their idle high level so no false edge follows reset
	pmcc_sync #(.W(SW), .INIT({{(SW - 2){1'b0}}, 2'b11})) u_sync (
		.clk(MCLK),
		.rst_n(RST_N),
		.d({FAULT_IN, VIN_OK, CONTROL_PIN, SECONDARY, STACK_POS, DEV_ADDR, SDA_I, SCL_I}),
		.q(pins_s)
	);
	assign scl_s = pins_s[0];
	assign sda_s = pins_s[1];
	assign dev_s = pins_s[8:2];
	assign stack_s = pins_s[10:9];
	assign sec_s = pins_s[11];
	assign pin_s = pins_s[12];
	assign vin_s = pins_s[13];
	assign flt_s = pins_s[SW-1:14];

	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			scl_p <= 1'b1;
			sda_p <= 1'b1;
		end else begin
			scl_p <= scl_s;
			sda_p <= sda_s;
		end
	end
	assign scl_rise = scl_s & ~scl_p;
	assign scl_fall = ~scl_s & scl_p;
	assign start_ev = scl_s & scl_p & sda_p & ~sda_s;
	assign stop_ev = scl_s & scl_p & ~sda_p & sda_s;

	// ----------------------------------------------------------------
	// target state machine
	// ----------------------------------------------------------------
	pmcc_state_e st_r;
	logic [3:0] bit_r;
	logic [7:0] sh_r, tx_r, cmd_r, op_r, cfg_r, rd_val, ld_byte, op_rd;
	logic oe_r, rw_r, ara_r, cmd_ok_r, got_data_r, first_r, more_r, alert_r;
	logic addr_dec, cmd_dec, data_dec, addr_hit, ara_hit, rd_ok;
	logic wr_commit, ivc_set, ivd_set, clr_cmd, ara_done, ara_lost;
	logic [NS-1:0] status_r, masked_r, set_vec, clr_vec, w1c_vec;
	logic run_on, clr_all;

	assign addr_dec = scl_fall && st_r == ST_ADDR && bit_r == 4'h8;
	assign cmd_dec = scl_fall && st_r == ST_CMD && bit_r == 4'h8;
	assign data_dec = scl_fall && st_r == ST_WDATA && bit_r == 4'h8;
	assign addr_hit = (sh_r[7:1] == dev_s);
	assign ara_hit = (sh_r[7:1] == `PMCC_ARA_ADDR) && sh_r[0] && alert_r;
	assign rd_ok = cmd_ok_r && acc_f(cmd_r, `PMCC_K_RD, sec_s);
	assign ara_lost = ara_r && !oe_r && !sda_s;
	assign ara_done = scl_rise && st_r == ST_RACK && ara_r;
	// the scl rise of the stop itself shifts one bit
	assign clr_cmd = stop_ev && st_r == ST_WDATA && bit_r == 4'h1 && cmd_ok_r && !got_data_r
		&& cmd_r == `PMCC_CMD_CLR;
	// later bytes of a read carry the upper bits, which are zero here
	assign ld_byte = !first_r ? 8'h00 : (ara_r ? {dev_s, 1'b0} : rd_val);

	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			st_r <= ST_IDLE;
			bit_r <= 4'h0;
			sh_r <= 8'h00;
			tx_r <= 8'h00;
			cmd_r <= 8'h00;
			oe_r <= 1'b0;
			rw_r <= 1'b0;
			ara_r <= 1'b0;
			cmd_ok_r <= 1'b0;
			got_data_r <= 1'b0;
			first_r <= 1'b0;
			more_r <= 1'b0;
		end else if (start_ev) begin
			st_r <= ST_ADDR;
			bit_r <= 4'h0;
			oe_r <= 1'b0;
		end else if (stop_ev) begin
			st_r <= ST_IDLE;
			oe_r <= 1'b0;
			cmd_ok_r <= 1'b0;
		end else if (scl_rise) begin
			case (st_r)
				ST_ADDR, ST_CMD, ST_WDATA: begin
					sh_r <= {sh_r[6:0], sda_s};
					bit_r <= bit_r + 4'h1;
				end
				ST_RDATA: begin
					if (ara_lost) begin
						st_r <= ST_IGNORE;
					end
				end
				ST_RACK: more_r <= ~sda_s;
				default: ;
			endcase
		end else if (scl_fall) begin
			case (st_r)
				ST_ADDR: begin
					if (bit_r == 4'h8) begin
						first_r <= 1'b1;
						if (addr_hit && (!sh_r[0] || rd_ok)) begin
							st_r <= ST_ADDR_ACK;
							oe_r <= 1'b1;
							rw_r <= sh_r[0];
							ara_r <= 1'b0;
						end else if (ara_hit) begin
							st_r <= ST_ADDR_ACK;
							oe_r <= 1'b1;
							rw_r <= 1'b1;
							ara_r <= 1'b1;
						end else begin
							st_r <= ST_IGNORE;
						end
					end
				end
				ST_ADDR_ACK, ST_RACK: begin
					oe_r <= 1'b0;
					if (st_r == ST_ADDR_ACK && !rw_r) begin
						st_r <= ST_CMD;
						bit_r <= 4'h0;
					end else if (st_r == ST_ADDR_ACK || (more_r && !ara_r)) begin
						st_r <= ST_RDATA;
						oe_r <= ~ld_byte[7];
						tx_r <= {ld_byte[6:0], 1'b0};
						bit_r <= 4'h1;
						first_r <= 1'b0;
					end else begin
						st_r <= ST_IGNORE;
					end
				end
				ST_RDATA: begin
					if (bit_r == 4'h8) begin
						oe_r <= 1'b0;
						st_r <= ST_RACK;
					end else begin
						oe_r <= ~tx_r[7];
						tx_r <= {tx_r[6:0], 1'b0};
						bit_r <= bit_r + 4'h1;
					end
				end
				ST_CMD: begin
					if (bit_r == 4'h8) begin
						cmd_r <= sh_r;
						cmd_ok_r <= acc_f(sh_r, `PMCC_K_CMD, sec_s);
						if (acc_f(sh_r, `PMCC_K_CMD, sec_s)) begin
							st_r <= ST_CMD_ACK;
							oe_r <= 1'b1;
						end else begin
							st_r <= ST_IGNORE;
						end
					end
				end
				ST_CMD_ACK: begin
					oe_r <= 1'b0;
					st_r <= ST_WDATA;
					bit_r <= 4'h0;
					got_data_r <= 1'b0;
				end
				ST_WDATA: begin
					if (bit_r == 4'h8) begin
						got_data_r <= 1'b1;
						if (acc_f(cmd_r, `PMCC_K_WR, sec_s)) begin
							st_r <= ST_WACK;
							oe_r <= 1'b1;
						end else begin
							st_r <= ST_IGNORE;
						end
					end
				end
				ST_WACK: begin
					oe_r <= 1'b0;
					st_r <= ST_IGNORE;
				end
				default: ;
			endcase
		end
	end
	assign SDA_O = 1'b0;
	assign SDA_OE = oe_r;

	// ----------------------------------------------------------------
	// command registers
	// ----------------------------------------------------------------
	assign wr_commit = data_dec && acc_f(cmd_r, `PMCC_K_WR, sec_s);
	assign ivd_set = wr_commit && ((cmd_r == `PMCC_CMD_OP && !op_valid_f(sh_r))
		|| (cmd_r == `PMCC_CMD_CFG && !cfg_valid_f(sh_r)));
	assign ivc_set = (addr_dec && addr_hit && sh_r[0] && !rd_ok)
		|| (cmd_dec && !acc_f(sh_r, `PMCC_K_CMD, sec_s))
		|| (data_dec && !acc_f(cmd_r, `PMCC_K_WR, sec_s));

	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			op_r <= `PMCC_OP_RST;
		end else if (wr_commit && cmd_r == `PMCC_CMD_OP && op_valid_f(sh_r)) begin
			op_r <= sh_r;
		end
	end

	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			cfg_r <= CFG_RST;
		end else if (wr_commit && cmd_r == `PMCC_CMD_CFG && cfg_valid_f(sh_r) && !sec_s) begin
			cfg_r <= sh_r;
		end
	end

	assign op_rd = {op_r[`PMCC_OP_ON] | sec_s, op_r[6:0]};
	always_comb begin
		case (cmd_r)
			`PMCC_CMD_OP: rd_val = op_rd;
			`PMCC_CMD_CFG: rd_val = cfg_r;
			`PMCC_CMD_PHASE: rd_val = {6'h00, stack_s};
			`PMCC_CMD_CML: rd_val = {status_r[BADC], status_r[IVD], 6'h00};
			`PMCC_CMD_FLT: rd_val = {{(8 - NF){1'b0}}, status_r[NF-1:0]};
			default: rd_val = 8'h00;
		endcase
	end

	// margin target and fault handling
	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			MARGIN_SEL <= MSEL_NOM;
			FAULT_IGNORE <= 1'b0;
		end else begin
			case (op_r[5:2])
				`PMCC_MRG_LO_IGN, `PMCC_MRG_LO_ACT: MARGIN_SEL <= MSEL_LOW;
				`PMCC_MRG_HI_IGN, `PMCC_MRG_HI_ACT: MARGIN_SEL <= MSEL_HIGH;
				default: MARGIN_SEL <= MSEL_NOM;
			endcase
			FAULT_IGNORE <= (op_r[5:2] == `PMCC_MRG_LO_IGN) || (op_r[5:2] == `PMCC_MRG_HI_IGN);
		end
	end

	pmcc_run_ctrl u_run (
		.clk(MCLK),
		.rst_n(RST_N),
		.vin_ok(vin_s),
		.pin(pin_s),
		.secondary(sec_s),
		.op_on(op_rd[`PMCC_OP_ON]),
		.op_soft(op_r[`PMCC_OP_SOFT]),
		.cfg_start(cfg_r[`PMCC_CFG_START]),
		.cfg_cmd(cfg_r[`PMCC_CFG_CMD]),
		.cfg_pinen(cfg_r[`PMCC_CFG_PINEN]),
		.cfg_pinoff(cfg_r[`PMCC_CFG_PINOFF]),
		.run_r(CONV_RUN),
		.soft_r(OFF_SOFT),
		.run_on(run_on)
	);

	// ----------------------------------------------------------------
	// status and alert
	// ----------------------------------------------------------------
	assign set_vec = {ivc_set, ivd_set, flt_s};
	assign clr_all = clr_cmd | run_on;
	always_comb begin
		w1c_vec = '0;
		if (wr_commit && cmd_r == `PMCC_CMD_CML) begin
			w1c_vec[BADC] = sh_r[`PMCC_CML_BADC];
			w1c_vec[IVD] = sh_r[`PMCC_CML_IVD];
		end else if (wr_commit && cmd_r == `PMCC_CMD_FLT) begin
			w1c_vec[NF-1:0] = sh_r[NF-1:0];
		end
	end
	assign clr_vec = {NS{clr_all}} | w1c_vec;

	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			status_r <= '0;
		end else begin
			status_r <= (status_r & ~clr_vec) | set_vec;
		end
	end

	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			masked_r <= '0;
		end else if (ara_done) begin
			masked_r <= status_r;
		end else begin
			masked_r <= masked_r & ~clr_vec;
		end
	end

	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			alert_r <= 1'b0;
		end else begin
			alert_r <= |(((status_r & ~clr_vec) | set_vec) & ~(ara_done ? status_r : masked_r & ~clr_vec));
		end
	end
	assign ALERT_O = 1'b0;
	assign ALERT_OE = alert_r;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	rsvd_bits_zero_a: assert property (@(posedge MCLK) disable iff (!RST_N)
		op_rd[1:0] == 2'b00 && cfg_r[7:5] == 3'b000) else $error("reserved bits not zero");
	polarity_fixed_a: assert property (@(posedge MCLK) disable iff (!RST_N)
		cfg_r[`PMCC_CFG_PINHI]) else $error("polarity bit cleared");
	sec_on_read_a: assert property (@(posedge MCLK) disable iff (!RST_N)
		sec_s |-> op_rd[`PMCC_OP_ON]) else $error("secondary on bit not one");
	margin_reset_a: assert property (@(posedge MCLK)
		$rose(RST_N) |-> op_r[5:2] == `PMCC_MRG_RST) else $error("margin reset value wrong");
	bad_op_flag_a: assert property (@(posedge MCLK) disable iff (!RST_N)
		(wr_commit && cmd_r == `PMCC_CMD_OP && !op_valid_f(sh_r)) |=> (status_r[IVD] && $stable(op_r)))
		else $error("invalid operation write not flagged");
	clear_all_a: assert property (@(posedge MCLK) disable iff (!RST_N)
		clr_cmd |=> (status_r == $past(set_vec))) else $error("clear faults left status");
	ara_release_a: assert property (@(posedge MCLK) disable iff (!RST_N)
		(ara_done && (set_vec & ~status_r) == '0 && !clr_all) |=> (!ALERT_OE && status_r == $past(status_r)))
		else $error("alert response did not release alert");
	new_fault_a: assert property (@(posedge MCLK) disable iff (!RST_N)
		((set_vec & ~status_r) != '0) |=> ALERT_OE) else $error("new fault did not alert");
	sec_cfg_nack_a: assert property (@(posedge MCLK) disable iff (!RST_N)
		(cmd_dec && sh_r == `PMCC_CMD_CFG && sec_s) |=> (st_r == ST_IGNORE && !SDA_OE && status_r[BADC]))
		else $error("secondary config access not refused");
	clear_cmd_c: cover property (@(posedge MCLK) disable iff (!RST_N) clr_cmd);
	ara_done_c: cover property (@(posedge MCLK) disable iff (!RST_N) ara_done);
	op_write_c: cover property (@(posedge MCLK) disable iff (!RST_N) wr_commit && cmd_r == `PMCC_CMD_OP);
endmodule : pmcc_top

// ### tb/pmcc_host.sv
// smbus host model for the conversion control register bank
`timescale 1ns/1ps
module pmcc_host (
	input wire logic clk,
	input wire logic sda_w,
	output logic scl,
	output logic sda
);
	initial begin
		scl = 1'b1;
		sda = 1'b1;
	end
	// ----------------------------------------------------------------
	// bus phases, every change at the falling core clock edge
	// ----------------------------------------------------------------
	task automatic tk(input int n);
		repeat (n) @(negedge clk);
	endtask : tk
	// start or repeated start, after the target lets go of its acknowledge
	task automatic start();
		tk(4);
		sda = 1'b1;
		tk(1);
		scl = 1'b1;
		tk(3);
		sda = 1'b0;
		tk(3);
		scl = 1'b0;
	endtask : start
	task automatic stop();
		tk(4);
		sda = 1'b0;
		tk(1);
		scl = 1'b1;
		tk(3);
		sda = 1'b1;
		tk(4);
	endtask : stop
	// eight bits msb first then the acknowledge slot; a 1 releases the line
	task automatic xfer(input logic [8:0] d, output logic [8:0] q);
		for (int i = 8; i >= 0; i--) begin
			tk(4);
			sda = d[i];
			tk(1);
			scl = 1'b1;
			tk(2);
			q[i] = sda_w;
			tk(1);
			scl = 1'b0;
		end
	endtask : xfer
endmodule : pmcc_host

// ### tb/test_pmcc_top.sv
// self-checking bench for the conversion control register bank
`timescale 1ns/1ps
module test_pmcc_top;
	logic mclk, rst_n, scl, h_sda, sda_o, sda_oe, alert_o, alert_oe;
	logic secondary, control_pin, vin_ok, conv_run, off_soft, fault_ignore;
	logic [6:0] dev_addr;
	logic [1:0] stack_pos, margin_sel;
	logic [3:0] fault_in;
	logic [7:0] d;
	logic [15:0] w;
	logic a;
	logic [3:0] mc [7] = '{4'h0, 4'h1, 4'h2, 4'h5, 4'h6, 4'h9, 4'hA};
	logic [1:0] ms [7] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h2};
	int bad_count = 0;
	int tests_run = 0;
	wire sda_w = ~sda_oe & h_sda;
	pmcc_top i_dut (.MCLK(mclk), .RST_N(rst_n), .SCL_I(scl), .SDA_I(sda_w), .SDA_O(sda_o),
		.SDA_OE(sda_oe), .ALERT_O(alert_o), .ALERT_OE(alert_oe), .DEV_ADDR(dev_addr),
		.SECONDARY(secondary), .STACK_POS(stack_pos), .CONTROL_PIN(control_pin), .VIN_OK(vin_ok),
		.FAULT_IN(fault_in), .CONV_RUN(conv_run), .OFF_SOFT(off_soft), .MARGIN_SEL(margin_sel),
		.FAULT_IGNORE(fault_ignore));
	pmcc_host i_host (.clk(mclk), .sda_w(sda_w), .scl(scl), .sda(h_sda));
	// ----------------------------------------------------------------
	// access tasks
	// ----------------------------------------------------------------
	task automatic tk(input int n);
		repeat (n) @(negedge mclk);
	endtask : tk
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		tests_run++;
		if (g !== e) begin
			bad_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk
	task automatic wr(input logic [7:0] c, input logic [7:0] v, output logic ak);
		logic [8:0] q0, q1, q2;
		i_host.start();
		i_host.xfer({dev_addr, 1'b0, 1'b1}, q0);
		i_host.xfer({c, 1'b1}, q1);
		i_host.xfer({v, 1'b1}, q2);
		i_host.stop();
		ak = ~(q0[0] | q1[0] | q2[0]);
	endtask : wr
	task automatic rd(input logic [7:0] c, output logic [7:0] v, output logic ak);
		logic [8:0] q0, q1, q2, q3;
		i_host.start();
		i_host.xfer({dev_addr, 1'b0, 1'b1}, q0);
		i_host.xfer({c, 1'b1}, q1);
		i_host.start();
		i_host.xfer({dev_addr, 1'b1, 1'b1}, q2);
		i_host.xfer(9'h1FF, q3);
		i_host.stop();
		v = q3[8:1];
		ak = ~(q0[0] | q1[0] | q2[0]);
	endtask : rd
	// two-byte read, host acknowledges the first byte
	task automatic rd_two(input logic [7:0] c, output logic [15:0] v);
		logic [8:0] q0, q1;
		i_host.start();
		i_host.xfer({dev_addr, 1'b0, 1'b1}, q0);
		i_host.xfer({c, 1'b1}, q0);
		i_host.start();
		i_host.xfer({dev_addr, 1'b1, 1'b1}, q0);
		i_host.xfer(9'h1FE, q0);
		i_host.xfer(9'h1FF, q1);
		i_host.stop();
		v = {q1[8:1], q0[8:1]};
	endtask : rd_two
	task automatic clr();
		logic [8:0] q;
		i_host.start();
		i_host.xfer({dev_addr, 1'b0, 1'b1}, q);
		i_host.xfer({8'h03, 1'b1}, q);
		i_host.stop();
	endtask : clr
	task automatic ara(output logic [7:0] v);
		logic [8:0] q0, q1;
		i_host.start();
		i_host.xfer({7'h0C, 1'b1, 1'b1}, q0);
		i_host.xfer(9'h1FF, q1);
		i_host.stop();
		v = q1[8:1];
	endtask : ara
	task automatic rc(input logic er);
		tk(6);
		chk({7'h0, conv_run}, {7'h0, er});
	endtask : rc
	task automatic test_done();
		$display("comparisons %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : test_done
	// ----------------------------------------------------------------
	// clock, watchdog and tests
	// ----------------------------------------------------------------
	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end
	initial begin
		repeat (40000) @(posedge mclk);
		bad_count++;
		test_done();
	end
	initial begin
		rst_n = 1'b0;
		dev_addr = 7'h2A;
		secondary = 1'b0;
		stack_pos = 2'b10;
		control_pin = 1'b0;
		vin_ok = 1'b1;
		fault_in = 4'h0;
		tk(5);
		rst_n = 1'b1;
		tk(5);
		rd(8'h01, d, a);
		chk(d, 8'h04);
		rd(8'h02, d, a);
		chk(d, 8'h16);
		rd(8'h04, d, a);
		chk(d, 8'h02);
		rd_two(8'h04, w);
		chk(w[7:0], 8'h02);
		chk(w[15:8], 8'h00);
		chk({7'h0, conv_run}, 8'h00);
		for (int i = 0; i < 7; i++) begin
			wr(8'h01, {2'b00, mc[i], 2'b00}, a);
			chk({5'h0, margin_sel, fault_ignore}, {5'h0, ms[i], mc[i] == 4'h5 || mc[i] == 4'h9});
			rd(8'h01, d, a);
			chk(d, {2'b00, mc[i], 2'b00});
		end
		wr(8'h01, 8'h05, a);
		chk({7'h0, a}, 8'h01);
		chk({7'h0, alert_oe}, 8'h01);
		wr(8'h02, 8'h34, a);
		rd(8'h01, d, a);
		chk(d, 8'h28);
		rd(8'h02, d, a);
		chk(d, 8'h16);
		rd(8'h7E, d, a);
		chk(d, 8'h40);
		clr();
		chk({7'h0, alert_oe}, 8'h00);
		rd(8'h7E, d, a);
		chk(d, 8'h00);
		wr(8'h01, 8'h04, a);
		control_pin = 1'b1;
		rc(1'b1);
		control_pin = 1'b0;
		rc(1'b0);
		chk({7'h0, off_soft}, 8'h01);
		wr(8'h02, 8'h1F, a);
		control_pin = 1'b1;
		rc(1'b0);
		wr(8'h01, 8'h84, a);
		rc(1'b1);
		control_pin = 1'b0;
		rc(1'b0);
		chk({7'h0, off_soft}, 8'h00);
		control_pin = 1'b1;
		rc(1'b1);
		wr(8'h01, 8'hC4, a);
		wr(8'h01, 8'h44, a);
		rc(1'b0);
		chk({7'h0, off_soft}, 8'h01);
		wr(8'h01, 8'h84, a);
		wr(8'h01, 8'h04, a);
		rc(1'b0);
		chk({7'h0, off_soft}, 8'h00);
		wr(8'h02, 8'h02, a);
		control_pin = 1'b0;
		rc(1'b1);
		vin_ok = 1'b0;
		rc(1'b0);
		fault_in = 4'h1;
		tk(6);
		chk({7'h0, alert_oe}, 8'h01);
		ara(d);
		chk(d, {dev_addr, 1'b0});
		chk({6'h0, sda_o, alert_o}, 8'h00);
		tk(4);
		chk({7'h0, alert_oe}, 8'h00);
		rd(8'h7F, d, a);
		chk(d, 8'h01);
		chk({7'h0, alert_oe}, 8'h00);
		fault_in = 4'h3;
		tk(6);
		chk({7'h0, alert_oe}, 8'h01);
		ara(d);
		tk(4);
		chk({7'h0, alert_oe}, 8'h00);
		clr();
		tk(4);
		chk({7'h0, alert_oe}, 8'h01);
		rd(8'h7F, d, a);
		chk(d, 8'h03);
		fault_in = 4'h0;
		tk(4);
		clr();
		chk({7'h0, alert_oe}, 8'h00);
		wr(8'h02, 8'h16, a);
		vin_ok = 1'b1;
		rc(1'b0);
		secondary = 1'b1;
		rc(1'b1);
		rd(8'h01, d, a);
		chk(d, 8'h84);
		rd(8'h02, d, a);
		chk({7'h0, a}, 8'h00);
		chk({7'h0, alert_oe}, 8'h01);
		wr(8'h02, 8'h02, a);
		chk({7'h0, a}, 8'h00);
		wr(8'h7E, 8'h80, a);
		rd(8'h7E, d, a);
		chk(d, 8'h00);
		chk({7'h0, alert_oe}, 8'h00);
		secondary = 1'b0;
		rc(1'b0);
		clr();
		rd(8'h02, d, a);
		chk(d, 8'h16);
		test_done();
	end
endmodule : test_pmcc_top
